// [hdl/cascade_sync_pkg.sv]
// How it works
// [RULE1] sender starts all streams together with JK
// [RULE2] align on JK, then signal cascade ready
// [RULE3] ready lines open-drain, wired-AND form start
// [RULE4] start high only after all devices release
// [RULE5] first JK goes to host, ready released
// [RULE6] at most two consecutive JKs to host
// [RULE7] start late by second byte-clock fall: error
// [RULE8] corrupted JK may go unreported
// [RULE9] sender frames at least three bytes
// [RULE10] sender frames at most 4500 bytes, delimited
// [RULE11] sender keeps JK arrival skew within 80 ns
// [RULE12] sender puts eight idles between frames
// [RULE13] with start high, pass data to host
// [RULE14] cascade enable bit gates all of this
package cascade_sync_pkg;

   // timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int BYTE_PERIOD_NS = 80;
   localparam int BYTE_DIV       = BYTE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FALL_LIMIT     = 2;
   localparam int MAX_JK_SHOWN   = 2;

   // frame limits
   localparam int FRAME_MIN      = 3;
   localparam int FRAME_MAX      = 4500;
   localparam int IDLE_MIN       = 8;
   localparam int FRAME_CNT_W    = 13;
   localparam int IDLE_CNT_W     = 4;

   // register map
   localparam logic [7:0] REG_CONFIG   = 8'h00;
   localparam logic [7:0] REG_RX_STATE = 8'h08;
   localparam logic [7:0] REG_RCOND_B  = 8'h0a;
   localparam logic [7:0] REG_RMASK_B  = 8'h0c;
   localparam logic [7:0] RESET_VALUE  = 8'h00;

   // field positions
   localparam int CFG_CASCADE_EN = 0;
   localparam int COND_SYNC_ERR  = 4;
   localparam int COND_SHORT     = 5;
   localparam int COND_LONG      = 6;
   localparam int COND_GAP       = 7;

   typedef enum logic [1:0] {
      HUNT,
      WAIT_START,
      PASS,
      DROP
   } align_t;

   typedef struct packed {
      logic       valid;
      logic       jk;
      logic       idle;
      logic       endDel;
      logic [7:0] data;
   } rx_pair_t;

   typedef struct packed {
      logic       valid;
      logic       jk;
      logic [7:0] data;
   } host_pair_t;

endpackage : cascade_sync_pkg

// [hdl/cascade_stream_sync.sv]
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module cascade_stream_sync #(
   parameter int BYTE_DIV   = cascade_sync_pkg::BYTE_DIV,
   parameter int FRAME_MAX  = cascade_sync_pkg::FRAME_MAX,
   parameter int FRAME_MIN  = cascade_sync_pkg::FRAME_MIN,
   parameter int IDLE_MIN   = cascade_sync_pkg::IDLE_MIN
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // register port
   input  wire logic [7:0]                   regAddr,
   input  wire logic [7:0]                   regWdata,
   input  wire logic                         regWe,
   input  wire logic                         regRe,
   output logic      [7:0]                   regRdata,
   // receive stream from the symbol decoder
   input  wire cascade_sync_pkg::rx_pair_t   rxIn,
   // stream to the host
   output cascade_sync_pkg::host_pair_t      hostOut,
   // open-drain cascade ready pin
   output logic                              readyO,
   output logic                              readyOe,
   // wired-AND cascade start pin
   input  wire logic                         startPin,
   // interrupt
   output logic                              irq
);

   localparam int FCW = cascade_sync_pkg::FRAME_CNT_W;
   localparam int ICW = cascade_sync_pkg::IDLE_CNT_W;
   localparam logic [FCW-1:0] FMAX = FCW'(FRAME_MAX);
   localparam logic [FCW-1:0] FMIN = FCW'(FRAME_MIN);
   localparam logic [ICW-1:0] IMIN = ICW'(IDLE_MIN);
   localparam logic [7:0] DIV_LAST = 8'(BYTE_DIV - 1);
   localparam logic [1:0] FALLS    = 2'(cascade_sync_pkg::FALL_LIMIT);
   localparam logic [1:0] JK_MAX   = 2'(cascade_sync_pkg::MAX_JK_SHOWN);

   // start pin synchroniser
   logic startMeta_r;
   logic startSync_r;

   // local byte clock divider
   logic [7:0] divCnt_r;
   logic [7:0] divCnt_nxt;
   logic       lbcFall;

   // alignment state
   cascade_sync_pkg::align_t     state_r;
   cascade_sync_pkg::align_t     state_nxt;
   logic [1:0]                   jkShown_r;
   logic [1:0]                   jkShown_nxt;
   logic [1:0]                   fallCnt_r;
   logic [1:0]                   fallCnt_nxt;
   logic [FCW-1:0]               frameCnt_r;
   logic [FCW-1:0]               frameCnt_nxt;
   logic [ICW-1:0]               idleCnt_r;
   logic [ICW-1:0]               idleCnt_nxt;
   logic                         frameSeen_r;
   logic                         frameSeen_nxt;
   logic                         readyOe_r;
   logic                         readyOe_nxt;
   cascade_sync_pkg::host_pair_t host_r;
   cascade_sync_pkg::host_pair_t host_nxt;
   logic                         evSync;
   logic                         evShort;
   logic                         evLong;
   logic                         evGap;
   logic                         startOk;

   // registers
   logic [7:0] config_r;
   logic [7:0] config_nxt;
   logic [7:0] condB_r;
   logic [7:0] condB_nxt;
   logic [7:0] maskB_r;
   logic [7:0] maskB_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [7:0] events;
   logic       cascadeEn;

   assign cascadeEn = config_r[cascade_sync_pkg::CFG_CASCADE_EN];

   // pin level crosses two flops before anyone looks at it
   always_ff @(posedge clk) begin
      if (rst) begin
         startMeta_r <= 1'b0;
         startSync_r <= 1'b0;
      end else begin
         startMeta_r <= startPin;
         startSync_r <= startMeta_r;
      end
   end

   // byte clock is high in the first half of its period, so the
   // falling edge is marked at the midpoint of the divider
   always_comb begin
      divCnt_nxt = (divCnt_r == DIV_LAST) ? 8'h00 : divCnt_r + 8'h01;
   end

   assign lbcFall = (divCnt_r == 8'(BYTE_DIV / 2));

   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_r <= 8'h00;
      end else begin
         divCnt_r <= divCnt_nxt;
      end
   end

   // our own release is part of the wired-AND; a stale high seen
   // while we still pull low cannot count as a start
   assign startOk = startSync_r && !readyOe_r; // see [RULE4]

   always_comb begin
      state_nxt     = state_r;
      jkShown_nxt   = jkShown_r;
      fallCnt_nxt   = fallCnt_r;
      frameCnt_nxt  = frameCnt_r;
      idleCnt_nxt   = idleCnt_r;
      frameSeen_nxt = frameSeen_r;
      readyOe_nxt   = readyOe_r;
      host_nxt      = '0;
      evSync        = 1'b0;
      evShort       = 1'b0;
      evLong        = 1'b0;
      evGap         = 1'b0;
      if (!cascadeEn) begin
         // plain single-stream mode: no alignment, data straight on
         state_nxt     = cascade_sync_pkg::HUNT; // see [RULE14]
         readyOe_nxt   = 1'b0;
         jkShown_nxt   = 2'h0;
         fallCnt_nxt   = 2'h0;
         frameSeen_nxt = 1'b0;
         idleCnt_nxt   = '0;
         host_nxt.valid = rxIn.valid;
         host_nxt.jk    = rxIn.jk;
         host_nxt.data  = rxIn.data;
      end else begin
         case (state_r)
            cascade_sync_pkg::HUNT: begin
               // hold the common line low until our JK shows up
               readyOe_nxt = 1'b1; // see [RULE3]
               if (rxIn.valid && rxIn.idle && idleCnt_r != '1) begin
                  idleCnt_nxt = idleCnt_r + ICW'(1);
               end
               if (rxIn.valid && rxIn.jk) begin
                  // a late start may later mean a corrupted JK elsewhere
                  // goes unnoticed; nothing here tries to catch that
                  state_nxt      = cascade_sync_pkg::WAIT_START; // see [RULE2], [RULE8]
                  readyOe_nxt    = 1'b0; // see [RULE5]
                  host_nxt.valid = 1'b1; // see [RULE5]
                  host_nxt.jk    = 1'b1;
                  host_nxt.data  = rxIn.data;
                  jkShown_nxt    = 2'h1;
                  fallCnt_nxt    = 2'h0;
                  frameCnt_nxt   = FCW'(1);
                  idleCnt_nxt    = '0;
                  evGap          = frameSeen_r && (idleCnt_r < IMIN);
                  frameSeen_nxt  = 1'b1;
               end
            end
            cascade_sync_pkg::WAIT_START: begin
               if (startOk) begin
                  state_nxt = cascade_sync_pkg::PASS; // see [RULE13]
                  if (rxIn.valid) begin
                     host_nxt.valid = 1'b1;
                     host_nxt.jk    = rxIn.jk;
                     host_nxt.data  = rxIn.data;
                     frameCnt_nxt   = frameCnt_r + FCW'(1);
                  end
               end else begin
                  // repeat the JK once while the others catch up
                  if (rxIn.valid && jkShown_r < JK_MAX) begin
                     host_nxt.valid = 1'b1; // see [RULE6]
                     host_nxt.jk    = 1'b1;
                     jkShown_nxt    = jkShown_r + 2'h1;
                  end
                  if (lbcFall) begin
                     fallCnt_nxt = fallCnt_r + 2'h1;
                     if (fallCnt_r + 2'h1 >= FALLS) begin
                        evSync    = 1'b1; // see [RULE7]
                        state_nxt = cascade_sync_pkg::DROP;
                     end
                  end
               end
            end
            cascade_sync_pkg::PASS: begin
               if (rxIn.valid) begin
                  host_nxt.valid = 1'b1; // see [RULE13]
                  host_nxt.jk    = rxIn.jk;
                  host_nxt.data  = rxIn.data;
                  if (frameCnt_r != '1) begin
                     frameCnt_nxt = frameCnt_r + FCW'(1);
                  end
                  if (rxIn.endDel) begin
                     evShort     = (frameCnt_r + FCW'(1)) < FMIN;
                     evLong      = frameCnt_r >= FMAX;
                     state_nxt   = cascade_sync_pkg::HUNT;
                     readyOe_nxt = 1'b1;
                  end
               end
            end
            cascade_sync_pkg::DROP: begin
               // misaligned frame is discarded up to its end
               if (rxIn.valid && (rxIn.endDel || rxIn.idle)) begin
                  state_nxt   = cascade_sync_pkg::HUNT;
                  readyOe_nxt = 1'b1;
                  idleCnt_nxt = '0;
               end
            end
            default: begin
               state_nxt = cascade_sync_pkg::HUNT;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r     <= cascade_sync_pkg::HUNT;
         jkShown_r   <= 2'h0;
         fallCnt_r   <= 2'h0;
         frameCnt_r  <= '0;
         idleCnt_r   <= '0;
         frameSeen_r <= 1'b0;
         readyOe_r   <= 1'b0;
         host_r      <= '0;
      end else begin
         state_r     <= state_nxt;
         jkShown_r   <= jkShown_nxt;
         fallCnt_r   <= fallCnt_nxt;
         frameCnt_r  <= frameCnt_nxt;
         idleCnt_r   <= idleCnt_nxt;
         frameSeen_r <= frameSeen_nxt;
         readyOe_r   <= readyOe_nxt;
         host_r      <= host_nxt;
      end
   end

   assign hostOut = host_r;
   assign readyO  = 1'b0; // see [RULE3]
   assign readyOe = readyOe_r;

   always_comb begin
      events = 8'h00;
      events[cascade_sync_pkg::COND_SYNC_ERR] = evSync;
      events[cascade_sync_pkg::COND_SHORT]    = evShort;
      events[cascade_sync_pkg::COND_LONG]     = evLong;
      events[cascade_sync_pkg::COND_GAP]      = evGap;
   end

   // register file; hardware set wins over a write-one clear
   always_comb begin
      config_nxt = config_r;
      maskB_nxt  = maskB_r;
      condB_nxt  = condB_r;
      rdata_nxt  = 8'h00;
      if (regWe) begin
         if (regAddr == cascade_sync_pkg::REG_CONFIG) begin
            config_nxt = regWdata & 8'h01;
         end else if (regAddr == cascade_sync_pkg::REG_RCOND_B) begin
            condB_nxt = condB_r & ~regWdata;
         end else if (regAddr == cascade_sync_pkg::REG_RMASK_B) begin
            maskB_nxt = regWdata;
         end
      end
      condB_nxt = condB_nxt | events; // see [RULE7]
      if (regRe) begin
         if (regAddr == cascade_sync_pkg::REG_CONFIG) begin
            rdata_nxt = config_r;
         end else if (regAddr == cascade_sync_pkg::REG_RX_STATE) begin
            rdata_nxt = {3'h0, startSync_r, readyOe_r, 1'b0, state_r};
         end else if (regAddr == cascade_sync_pkg::REG_RCOND_B) begin
            rdata_nxt = condB_r;
         end else if (regAddr == cascade_sync_pkg::REG_RMASK_B) begin
            rdata_nxt = maskB_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         config_r <= cascade_sync_pkg::RESET_VALUE;
         condB_r  <= cascade_sync_pkg::RESET_VALUE;
         maskB_r  <= cascade_sync_pkg::RESET_VALUE;
         rdata_r  <= 8'h00;
      end else begin
         config_r <= config_nxt;
         condB_r  <= condB_nxt;
         maskB_r  <= maskB_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign irq      = |(condB_r & maskB_r);

endmodule : cascade_stream_sync

// [tb/cascade_peer_model.sv]
`timescale 1ns/1ps
module cascade_peer_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // peer link events
   input  wire logic       peerJk,
   input  wire logic       peerEnd,
   input  wire logic [7:0] peerDelay,
   // shared cascade lines
   input  wire logic       dutOe,
   output logic            startPin
);
   logic       holdOe_r;
   logic       armed_r;
   logic [7:0] cnt_r;
   // delay stands for the skew of the peer's own JK arrival
   always @(posedge clk) begin
      if (rst || peerEnd) begin
         holdOe_r <= 1'b1;
         armed_r  <= 1'b0;
         cnt_r    <= 8'h00;
      end else if (peerJk) begin
         armed_r <= 1'b1;
         cnt_r   <= peerDelay;
      end else if (armed_r && cnt_r == 8'h00) begin
         holdOe_r <= 1'b0;
         armed_r  <= 1'b0;
      end else if (armed_r) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   // pull-up: high only while nobody pulls low
   assign startPin = !(dutOe || holdOe_r);
endmodule : cascade_peer_model

// [tb/cascade_stream_sync_checker.sv]
`timescale 1ns/1ps
module cascade_stream_sync_checker (
   // watched ports
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic                       regWe,
   input wire logic                       regRe,
   input wire logic [7:0]                 regRdata,
   input wire cascade_sync_pkg::rx_pair_t rxIn,
   input wire cascade_sync_pkg::host_pair_t hostOut,
   input wire logic                       readyO,
   input wire logic                       readyOe,
   input wire logic                       irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [1:0] jkRun_r;
   logic [1:0] jkRun_nxt;
   always_comb begin
      jkRun_nxt = jkRun_r;
      if (readyOe) begin
         jkRun_nxt = 2'h0;
      end else if (hostOut.valid) begin
         jkRun_nxt = !hostOut.jk ? 2'h0 : (jkRun_r == 2'h3) ? 2'h3 : jkRun_r + 2'h1;
      end
   end
   always_ff @(posedge clk) begin
      jkRun_r <= rst ? 2'h0 : jkRun_nxt;
   end
   sequence jkTaken;
      readyOe && rxIn.valid && rxIn.jk && !regWe;
   endsequence
   sequence jkShown;
      hostOut.valid && hostOut.jk && !readyOe;
   endsequence
   a_jk_release: assert property (jkTaken |=> jkShown ##1 !readyOe)
      else $error("JK not shown with ready released");
   a_jk_run_limit: assert property (jkRun_r <= 2'h2)
      else $error("more than two JKs in a row");
   // a config write drops the enable one edge later and the pin one edge after that
   a_release_cause: assert property ($fell(readyOe) && !$past(regWe, 2) && !$past(rst)
      |-> $past(rxIn.valid) && $past(rxIn.jk))
      else $error("ready released without JK");
   a_ready_hold: assert property (readyOe && !rxIn.valid && !regWe && !$past(regWe) |=> readyOe)
      else $error("ready released while idle");
   a_host_cause: assert property (hostOut.valid |-> $past(rxIn.valid))
      else $error("host byte without input byte");
   a_od_drive: assert property (readyO == 1'b0)
      else $error("open-drain pin driven high");
   a_rdata_idle: assert property (!$past(regRe) |-> regRdata == 8'h00)
      else $error("read data outside answer cycle");
   a_reset_quiet: assert property ($past(rst) |-> hostOut == 10'h000 && !readyOe && !irq)
      else $error("outputs active after reset");
endmodule : cascade_stream_sync_checker
bind cascade_stream_sync cascade_stream_sync_checker u_checker (.clk(clk), .rst(rst), .regWe(regWe),
   .regRe(regRe), .regRdata(regRdata), .rxIn(rxIn), .hostOut(hostOut), .readyO(readyO),
   .readyOe(readyOe), .irq(irq));

// [tb/test_cascade_stream_sync.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errCount++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_cascade_stream_sync;
   logic                         clk;
   logic                         rst;
   logic [7:0]                   regAddr;
   logic [7:0]                   regWdata;
   logic [7:0]                   regRdata;
   logic                         regWe;
   logic                         regRe;
   cascade_sync_pkg::rx_pair_t   rxIn;
   cascade_sync_pkg::host_pair_t hostOut;
   cascade_sync_pkg::host_pair_t h;
   logic                         readyO;
   logic                         readyOe;
   logic                         startPin;
   logic                         irq;
   logic                         peerJk;
   logic                         peerEnd;
   logic [7:0]                   peerDelay;
   logic [7:0]                   d;
   int                           errCount = 0;
   int                           comparisons = 0;
   int                           cycles = 0;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errCount++;
         conclude();
      end
   end
   cascade_stream_sync u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
      .regRe(regRe), .regRdata(regRdata), .rxIn(rxIn), .hostOut(hostOut), .readyO(readyO),
      .readyOe(readyOe), .startPin(startPin), .irq(irq));
   cascade_peer_model u_peer (.clk(clk), .rst(rst), .peerJk(peerJk), .peerEnd(peerEnd),
      .peerDelay(peerDelay), .dutOe(readyOe), .startPin(startPin));
   task automatic regWrite(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regWe <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWe <= 1'b0;
      #1;
   endtask : regWrite
   task automatic regRead(input logic [7:0] a);
      @(posedge clk);
      regRe <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRe <= 1'b0;
      #1 d = regRdata;
   endtask : regRead
   task automatic sendByte(input logic jk, input logic en, input logic [7:0] v, input int gap);
      @(posedge clk);
      rxIn <= {1'b1, jk, 1'b0, en, v};
      @(posedge clk);
      rxIn <= 12'h000;
      #1 h = hostOut;
      repeat (gap) @(posedge clk);
      #1;
   endtask : sendByte
   task automatic peerAlign(input logic [7:0] dly);
      @(posedge clk);
      peerDelay <= dly;
      peerJk <= 1'b1;
      @(posedge clk);
      peerJk <= 1'b0;
   endtask : peerAlign
   task automatic peerFinish();
      @(posedge clk);
      peerEnd <= 1'b1;
      @(posedge clk);
      peerEnd <= 1'b0;
   endtask : peerFinish
   // idle pairs stay valid back to back, one per clock
   task automatic sendIdles(input int n);
      @(posedge clk);
      rxIn <= {1'b1, 1'b0, 1'b1, 1'b0, 8'h00};
      repeat (n) @(posedge clk);
      rxIn <= 12'h000;
      #1;
   endtask : sendIdles
   task automatic checkRegs();
      logic [7:0] addrs [4];
      addrs = '{cascade_sync_pkg::REG_CONFIG, cascade_sync_pkg::REG_RCOND_B, cascade_sync_pkg::REG_RMASK_B, 8'h3f};
      for (int i = 0; i < 4; i++) begin
         regRead(addrs[i]);
         `CHK(d, 8'h00)
      end
      regWrite(cascade_sync_pkg::REG_CONFIG, 8'hff);
      regRead(cascade_sync_pkg::REG_CONFIG);
      `CHK(d, 8'h01)
      regWrite(cascade_sync_pkg::REG_CONFIG, 8'h00);
   endtask : checkRegs
   task automatic passDisabled();
      sendByte(1'b0, 1'b0, 8'h5a, 2);
      `CHK(h, 10'h25a)
      `CHK(readyOe, 1'b0)
   endtask : passDisabled
   task automatic alignedFrame();
      regWrite(cascade_sync_pkg::REG_CONFIG, 8'h01);
      repeat (3) @(posedge clk);
      #1 `CHK(readyOe, 1'b1)
      peerAlign(8'h02);
      sendByte(1'b1, 1'b0, 8'h00, 12);
      `CHK({h.valid, h.jk}, 2'b11)
      `CHK(readyOe, 1'b0)
      sendByte(1'b0, 1'b0, 8'h3c, 12);
      `CHK(h, 10'h23c)
      sendByte(1'b0, 1'b1, 8'h77, 4);
      `CHK(h.valid, 1'b1)
      `CHK(readyOe, 1'b1)
      peerFinish();
      regRead(cascade_sync_pkg::REG_RCOND_B);
      `CHK(d, 8'h00)
   endtask : alignedFrame
   task automatic lateStart();
      // a full interframe gap, so only the sync error may show
      sendIdles(cascade_sync_pkg::IDLE_MIN);
      peerAlign(8'hc8);
      sendByte(1'b1, 1'b0, 8'h00, 3);
      `CHK({h.valid, h.jk}, 2'b11)
      sendByte(1'b0, 1'b0, 8'h11, 0);
      `CHK(h, 10'h300)
      sendByte(1'b0, 1'b0, 8'h22, 40);
      `CHK(h.valid, 1'b0)
      regRead(cascade_sync_pkg::REG_RCOND_B);
      `CHK(d, 8'h10)
      `CHK(irq, 1'b0)
      regWrite(cascade_sync_pkg::REG_RMASK_B, 8'h10);
      `CHK(irq, 1'b1)
      regWrite(cascade_sync_pkg::REG_RCOND_B, 8'h10);
      `CHK(irq, 1'b0)
      regRead(cascade_sync_pkg::REG_RCOND_B);
      `CHK(d, 8'h00)
      sendByte(1'b0, 1'b1, 8'h00, 4);
      `CHK(readyOe, 1'b1)
      peerFinish();
   endtask : lateStart
   // sender breaks its own limits: no idles before the JK, two-byte frame
   task automatic gapShort();
      peerAlign(8'h00);
      sendByte(1'b1, 1'b0, 8'h00, 6);
      `CHK({h.valid, h.jk}, 2'b11)
      sendByte(1'b0, 1'b1, 8'h55, 4);
      `CHK(h, 10'h255)
      regRead(cascade_sync_pkg::REG_RCOND_B);
      `CHK(d, 8'ha0)
      `CHK(d[cascade_sync_pkg::COND_GAP], 1'b1)
      `CHK(irq, 1'b0)
      regWrite(cascade_sync_pkg::REG_RCOND_B, 8'hff);
      peerFinish();
   endtask : gapShort
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   initial begin
      rst = 1'b1;
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWe = 1'b0;
      regRe = 1'b0;
      rxIn = 12'h000;
      peerJk = 1'b0;
      peerEnd = 1'b0;
      peerDelay = 8'h02;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      checkRegs();
      passDisabled();
      alignedFrame();
      lateStart();
      gapShort();
      conclude();
   end
endmodule : test_cascade_stream_sync
